//--- logic/sesp_consts.svh
/*
 * Constants of the serial EEPROM slave protocol: array geometry, timing
 * counts and buffer sizes.
 * Assumes the system clock figures below match the real clk_sys rate.
 */
`ifndef SESP_CONSTS_SVH
`define SESP_CONSTS_SVH

// System clock.
`define SESP_CLK_HZ 20000000
`define SESP_CLK_NS 50

// Array and page geometry.
`define SESP_ADDR_W 15
`define SESP_PAGE_AW 6
`define SESP_PAGE_BYTES 64

// Control byte fields.
`define SESP_CTRL_RW_BIT 0
`define SESP_CTRL_CS_LSB 1
`define SESP_CTRL_TYPE_LSB 4
// Device type code; the value is arbitrary.
`define SESP_DEV_TYPE 4'h6

// Self-timed write cycle.
`define SESP_WRITE_MS 5
`define SESP_WRITE_CYCLES ((`SESP_WRITE_MS * `SESP_CLK_HZ) / 1000)

// Bus clock made by the master, one quarter period per step.
`define SESP_SCL_PERIOD_NS 1000
`define SESP_QUARTER_CYCLES (`SESP_SCL_PERIOD_NS / (4 * `SESP_CLK_NS))

// Response buffer of the master.
`define SESP_FIFO_DEPTH 2
`define SESP_RSP_W 9

`endif

//--- logic/sesp_pkg.sv
/*
 * Types shared by both ends of the serial EEPROM link.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package sesp_pkg;

    typedef enum logic [2:0] {
        SESP_D_IDLE,
        SESP_D_CTRL,
        SESP_D_ADDR_HI,
        SESP_D_ADDR_LO,
        SESP_D_WDATA,
        SESP_D_RDATA,
        SESP_D_SKIP
    } sesp_dev_state_t;

    typedef enum logic [2:0] {
        SESP_M_IDLE,
        SESP_M_START,
        SESP_M_BIT,
        SESP_M_STOP,
        SESP_M_DONE
    } sesp_mst_state_t;

endpackage

`default_nettype wire

//--- logic/sesp_bus_if.sv
/*
 * Two-wire bus between the master end and the EEPROM end.
 * SDA is open drain: a party that enables its output pulls the line low,
 * otherwise the pull-up leaves it high. SCL is driven by the master only.
 */
`default_nettype none

interface sesp_bus_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic sda;

    assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

    modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
    modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface

`default_nettype wire

//--- logic/sesp_master.sv
/*
 * Master end: makes SCL from clk_sys, sends START, STOP and bytes, and
 * returns each byte's result through a small response buffer.
 * Assumes a single master on the bus and a user who sends START before
 * the first byte of a transfer.
 */
`include "sesp_consts.svh"
`default_nettype none

module sesp_master #(
    parameter int QUARTER = `SESP_QUARTER_CYCLES,
    parameter int DEPTH = `SESP_FIFO_DEPTH,
    parameter int RW = `SESP_RSP_W
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    sesp_bus_if.master bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_start,
    input wire logic cmd_stop,
    input wire logic cmd_read,
    input wire logic cmd_ack,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [7:0] rsp_data,
    output logic rsp_ack
);

    localparam int DW = $clog2(QUARTER + 1);

    sesp_pkg::sesp_mst_state_t state_reg;
    logic [DW-1:0] div_reg;
    logic tick;
    logic [1:0] q_reg;
    logic [3:0] bit_reg;
    logic scl_reg;
    logic drive_reg;
    logic [7:0] sh_reg;
    logic ack_seen_reg;
    logic stop_reg;
    logic read_reg;
    logic mack_reg;
    logic ready_reg;
    logic sda_s1_reg;
    logic sda_s2_reg;
    logic accept;
    logic push;
    logic pop;
    logic [RW-1:0] slot_reg [DEPTH];
    logic [DEPTH:0] vld_reg;
    logic [DEPTH:0] shv;

    assign tick = (div_reg == DW'(QUARTER - 1));
    assign accept = cmd_valid && ready_reg;
    assign push = (state_reg == sesp_pkg::SESP_M_DONE);
    assign pop = rsp_ready && vld_reg[0];

    assign bus.scl = scl_reg;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe = drive_reg;
    assign cmd_ready = ready_reg;
    assign rsp_valid = vld_reg[0];
    assign rsp_data = slot_reg[0][7:0];
    assign rsp_ack = slot_reg[0][8];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
        end
        else
        begin
            sda_s1_reg <= bus.sda;
            sda_s2_reg <= sda_s1_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            div_reg <= '0;
        else if (tick)
            div_reg <= '0;
        else
            div_reg <= DW'(div_reg + 1'b1);
    end

    // The buffer only grows in DONE, so a one-cycle-late ready is safe.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            ready_reg <= 1'b0;
        else
            ready_reg <= (state_reg == sesp_pkg::SESP_M_IDLE) && !accept &&
                         (!vld_reg[DEPTH-1] || pop);
    end

    ////////////////////////////////////////////////////////////////////////
    // Between commands without STOP, SCL is held low, which stalls the
    // bus until the next command is accepted, which waits while the response buffer is full.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= sesp_pkg::SESP_M_IDLE;
            q_reg <= 2'h0;
            bit_reg <= 4'h0;
            scl_reg <= 1'b1;
            drive_reg <= 1'b0;
            sh_reg <= 8'h00;
            ack_seen_reg <= 1'b0;
            stop_reg <= 1'b0;
            read_reg <= 1'b0;
            mack_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                sesp_pkg::SESP_M_IDLE:
                    if (accept)
                    begin
                        sh_reg <= cmd_data;
                        stop_reg <= cmd_stop;
                        read_reg <= cmd_read;
                        mack_reg <= cmd_ack;
                        q_reg <= 2'h0;
                        bit_reg <= 4'h0;
                        state_reg <= cmd_start ? sesp_pkg::SESP_M_START
                                               : sesp_pkg::SESP_M_BIT;
                    end
                sesp_pkg::SESP_M_START:
                    if (tick)
                    begin
                        q_reg <= 2'(q_reg + 2'h1);
                        case (q_reg)
                            2'h0: drive_reg <= 1'b0;
                            2'h1: scl_reg <= 1'b1;
                            2'h2: drive_reg <= 1'b1;
                            default:
                            begin
                                scl_reg <= 1'b0;
                                state_reg <= sesp_pkg::SESP_M_BIT;
                            end
                        endcase
                    end
                sesp_pkg::SESP_M_BIT:
                    if (tick)
                    begin
                        q_reg <= 2'(q_reg + 2'h1);
                        case (q_reg)
                            2'h0:
                                if (bit_reg != 4'h8)
                                    drive_reg <= !read_reg && !sh_reg[7];
                                else // see [R19]
                                    drive_reg <= read_reg && mack_reg;
                            2'h1: scl_reg <= 1'b1;
                            2'h2:
                                if (bit_reg != 4'h8)
                                    sh_reg <= {sh_reg[6:0], sda_s2_reg};
                                else
                                    ack_seen_reg <= !sda_s2_reg; // see [R16]
                            default:
                            begin
                                scl_reg <= 1'b0;
                                if (bit_reg == 4'h8)
                                begin
                                    bit_reg <= 4'h0;
                                    state_reg <= stop_reg
                                        ? sesp_pkg::SESP_M_STOP
                                        : sesp_pkg::SESP_M_DONE;
                                end
                                else
                                    bit_reg <= 4'(bit_reg + 4'h1);
                            end
                        endcase
                    end
                sesp_pkg::SESP_M_STOP:
                    if (tick)
                    begin
                        q_reg <= 2'(q_reg + 2'h1);
                        case (q_reg)
                            2'h0: drive_reg <= 1'b1;
                            2'h1: scl_reg <= 1'b1;
                            2'h2: drive_reg <= 1'b0;
                            default: state_reg <= sesp_pkg::SESP_M_DONE;
                        endcase
                    end
                sesp_pkg::SESP_M_DONE:
                    state_reg <= sesp_pkg::SESP_M_IDLE;
                default:
                    state_reg <= sesp_pkg::SESP_M_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift buffer: the head entry is a flop, so outputs need no read mux.
    assign shv[DEPTH] = 1'b0;
    assign vld_reg[DEPTH] = 1'b0;

    generate
        for (genvar i = 0; i < DEPTH; i++)
        begin : g_slot
            logic take;
            assign shv[i] = pop ? vld_reg[i+1] : vld_reg[i];
            if (i == 0)
            begin : g_first
                assign take = push && !shv[0];
            end
            else
            begin : g_rest
                assign take = push && !shv[i] && shv[i-1];
            end

            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    vld_reg[i] <= 1'b0;
                    slot_reg[i] <= '0;
                end
                else
                begin
                    vld_reg[i] <= shv[i] || take;
                    if (take)
                        slot_reg[i] <= {ack_seen_reg, sh_reg};
                    else if (pop && (i < DEPTH - 1))
                        slot_reg[i] <= slot_reg[(i < DEPTH - 1) ? i + 1 : i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- logic/sesp_eeprom.sv
/*
 * EEPROM end: decodes the control byte, takes the word address, buffers
 * page writes, runs the self-timed write cycle and serves reads.
 * Assumes SCL and SDA arrive from another clock domain and that SCL
 * phases last several clk_sys cycles.
 */
`include "sesp_consts.svh"
`default_nettype none

// Functional notes
// [R01] First byte: type code, selects, direction.
// [R02] Answer only when select bits match pins.
// [R03] Direction bit one reads, zero writes.
// [R04] Two address bytes, high first, top bit ignored.
// [R05] Matching control byte is acknowledged, then proceed.
// [R06] Every received byte acknowledged on ninth clock.
// [R07] STOP after data starts the write cycle.
// [R08] No acknowledge at all while writing.
// [R09] Protected write acknowledged but never committed.
// [R10] After byte write, pointer is next address.
// [R11] Page buffer takes up to 64 bytes.
// [R12] Only low six pointer bits advance on writes.
// [R13] Protect input high blocks the whole array.
// [R14] Protect input sampled at the ending STOP.
// [R15] Write cycle finishes within five milliseconds.
// [R16] Master polls with write control bytes.
// [R17] Pointer holds last accessed address plus one.
// [R18] Read sends byte at pointer, MSB first.
// [R19] Master ends read with no acknowledge, STOP.
// [R20] Repeated START after address keeps the pointer.
// [R21] After random read, pointer is next address.
// [R22] Acknowledged read continues; pointer wraps at top.
// [R23] Unacknowledged read releases SDA.
// [R24] Mid-byte START or STOP aborts without writing.
module sesp_eeprom #(
    parameter int WRITE_CYCLES = `SESP_WRITE_CYCLES,
    parameter logic [3:0] DEV_TYPE = `SESP_DEV_TYPE
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    sesp_bus_if.dev bus,
    input wire logic [2:0] chip_select_pins,
    input wire logic write_protect_input,
    output logic write_busy
);

    localparam int AW = `SESP_ADDR_W;
    localparam int PW = `SESP_PAGE_AW;
    localparam int PB = `SESP_PAGE_BYTES;
    localparam int CW = $clog2(WRITE_CYCLES + 1);

    logic [5:0] s1_reg;
    logic [5:0] s2_reg;
    logic scl_p_reg;
    logic sda_p_reg;
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic [2:0] cs_s;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    sesp_pkg::sesp_dev_state_t state_reg;
    logic [3:0] bit_reg;
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    logic [AW-1:0] ptr_reg;
    logic mack_reg;
    logic oe_reg;
    logic ctrl_match;
    logic byte_done;
    logic wr_byte;
    logic commit_go;
    logic busy_reg;
    logic [CW-1:0] cyc_reg;
    logic [PW:0] cidx_reg;
    logic [AW-PW-1:0] page_reg;
    logic [7:0] buf_reg [PB];
    logic [PB-1:0] mask_reg;
    logic [7:0] mem_reg [2**AW];

    assign {scl_s, sda_s, wp_s, cs_s} = s2_reg;
    assign scl_rise = scl_s && !scl_p_reg;
    assign scl_fall = !scl_s && scl_p_reg;
    assign start_cond = scl_s && scl_p_reg && sda_p_reg && !sda_s;
    assign stop_cond = scl_s && scl_p_reg && !sda_p_reg && sda_s;
    assign byte_done = scl_fall && (bit_reg == 4'h7);
    assign wr_byte = byte_done && (state_reg == sesp_pkg::SESP_D_WDATA);
    assign ctrl_match =
        (rx_reg[7:`SESP_CTRL_TYPE_LSB] == DEV_TYPE) && // see [R01]
        (rx_reg[`SESP_CTRL_TYPE_LSB-1:`SESP_CTRL_CS_LSB] == cs_s) &&
        !busy_reg; // see [R02] [R08]
    // Only a STOP on a byte boundary after data commits. see [R07] [R24]
    assign commit_go = stop_cond && (state_reg == sesp_pkg::SESP_D_WDATA) &&
                       (bit_reg == 4'h0) && (|mask_reg) && !busy_reg &&
                       !wp_s; // see [R09] [R13] [R14]

    assign bus.d_sda_o = 1'b0;
    assign bus.d_sda_oe = oe_reg;
    assign write_busy = busy_reg;

    ////////////////////////////////////////////////////////////////////////
    // The first stage is read by the second stage only.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_reg <= 6'h30;
            s2_reg <= 6'h30;
            scl_p_reg <= 1'b1;
            sda_p_reg <= 1'b1;
        end
        else
        begin
            s1_reg <= {bus.scl, bus.sda, write_protect_input,
                       chip_select_pins};
            s2_reg <= s1_reg;
            scl_p_reg <= scl_s;
            sda_p_reg <= sda_s;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            rx_reg <= 8'h00;
        else if (scl_rise && (bit_reg != 4'h8))
            rx_reg <= {rx_reg[6:0], sda_s}; // see [R01]
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte sequencing. SDA is changed only on a seen SCL fall, so the
    // device never makes a START or STOP of its own.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= sesp_pkg::SESP_D_IDLE;
            bit_reg <= 4'h0;
            tx_reg <= 8'h00;
            ptr_reg <= '0;
            mack_reg <= 1'b0;
            oe_reg <= 1'b0;
        end
        else if (start_cond)
        begin
            // The pointer is left as it stands. see [R20] [R24]
            state_reg <= sesp_pkg::SESP_D_CTRL;
            // The START's own SCL fall wraps the count to zero.
            bit_reg <= 4'hF;
            oe_reg <= 1'b0;
        end
        else if (stop_cond)
        begin
            state_reg <= sesp_pkg::SESP_D_IDLE; // see [R24]
            bit_reg <= 4'h0;
            oe_reg <= 1'b0;
        end
        else if ((state_reg != sesp_pkg::SESP_D_IDLE) &&
                 (state_reg != sesp_pkg::SESP_D_SKIP))
        begin
            if (scl_rise && (bit_reg == 4'h8))
                mack_reg <= !sda_s; // see [R22]
            if (scl_fall)
            begin
                bit_reg <= (bit_reg == 4'h8) ? 4'h0 : 4'(bit_reg + 4'h1);
                if (bit_reg == 4'h7)
                begin
                    oe_reg <= 1'b0;
                    case (state_reg)
                        sesp_pkg::SESP_D_CTRL:
                            if (ctrl_match)
                            begin
                                oe_reg <= 1'b1; // see [R05] [R06]
                                mack_reg <= 1'b1;
                                state_reg <= rx_reg[`SESP_CTRL_RW_BIT]
                                    ? sesp_pkg::SESP_D_RDATA
                                    : sesp_pkg::SESP_D_ADDR_HI; // see [R03]
                            end
                            else // see [R02]
                                state_reg <= sesp_pkg::SESP_D_SKIP;
                        sesp_pkg::SESP_D_ADDR_HI:
                        begin
                            ptr_reg[AW-1:8] <= rx_reg[AW-9:0]; // see [R04]
                            oe_reg <= 1'b1; // see [R06]
                            state_reg <= sesp_pkg::SESP_D_ADDR_LO;
                        end
                        sesp_pkg::SESP_D_ADDR_LO:
                        begin
                            ptr_reg[7:0] <= rx_reg; // see [R04]
                            oe_reg <= 1'b1; // see [R06]
                            state_reg <= sesp_pkg::SESP_D_WDATA;
                        end
                        sesp_pkg::SESP_D_WDATA:
                        begin
                            // Wraps within the page. see [R10] [R12]
                            ptr_reg[PW-1:0] <= PW'(ptr_reg[PW-1:0] + 1'b1);
                            oe_reg <= 1'b1; // see [R06]
                        end
                        default:
                            oe_reg <= 1'b0; // see [R23]
                    endcase
                end
                else if (bit_reg == 4'h8)
                begin
                    oe_reg <= 1'b0;
                    if (state_reg == sesp_pkg::SESP_D_RDATA)
                    begin
                        if (mack_reg)
                        begin
                            tx_reg <= mem_reg[ptr_reg]; // see [R18]
                            oe_reg <= !mem_reg[ptr_reg][7];
                            // Full-width wrap. see [R17] [R21] [R22]
                            ptr_reg <= AW'(ptr_reg + 1'b1);
                        end
                        else
                            state_reg <= sesp_pkg::SESP_D_SKIP; // see [R23]
                    end
                end
                else if (state_reg == sesp_pkg::SESP_D_RDATA)
                begin
                    tx_reg <= {tx_reg[6:0], 1'b0}; // see [R18]
                    oe_reg <= !tx_reg[6];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Page buffer. Marks survive a START during the write cycle, since a
    // poll arrives while the buffer is still being committed.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            mask_reg <= '0;
        else if (busy_reg)
        begin
            if (cidx_reg[PW])
                mask_reg <= '0;
        end
        else if (wr_byte)
            mask_reg[ptr_reg[PW-1:0]] <= 1'b1; // see [R11] [R12]
        else if ((start_cond || stop_cond) && !commit_go)
            mask_reg <= '0; // see [R09] [R20] [R24]
    end

    always_ff @(posedge clk_sys)
    begin
        if (wr_byte && !busy_reg)
            buf_reg[ptr_reg[PW-1:0]] <= rx_reg; // see [R11] [R12]
    end

    ////////////////////////////////////////////////////////////////////////
    // Write cycle: one page entry per clock, then wait out the full time.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy_reg <= 1'b0;
            cyc_reg <= '0;
            cidx_reg <= '0;
            page_reg <= '0;
        end
        else if (commit_go)
        begin
            busy_reg <= 1'b1; // see [R07]
            cyc_reg <= '0;
            cidx_reg <= '0;
            page_reg <= ptr_reg[AW-1:PW];
        end
        else if (busy_reg)
        begin
            if (!cidx_reg[PW])
                cidx_reg <= (PW+1)'(cidx_reg + 1'b1);
            if ((cyc_reg >= CW'(WRITE_CYCLES - 1)) && cidx_reg[PW])
                busy_reg <= 1'b0; // see [R15]
            else
                cyc_reg <= CW'(cyc_reg + 1'b1);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (busy_reg && !cidx_reg[PW] && mask_reg[cidx_reg[PW-1:0]])
            mem_reg[{page_reg, cidx_reg[PW-1:0]}] <=
                buf_reg[cidx_reg[PW-1:0]]; // see [R07] [R11]
    end

endmodule

`default_nettype wire

//--- dv/sesp_monitor.sv
/* Checker of the two-wire bus and of the EEPROM write cycle.
   Assumes the bench wires it beside the interface joining both ends. */
`default_nettype none

module sesp_monitor #(
    parameter int WRITE_CYCLES = 600
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic d_sda_oe,
    input wire logic write_protect_input,
    input wire logic write_busy
);
    int busy_cnt_reg;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            busy_cnt_reg <= 0;
        else
            busy_cnt_reg <= write_busy ? busy_cnt_reg + 1 : 0;
    end

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////
    AST_NO_ACK_BUSY: assert property (write_busy |-> !d_sda_oe)
        else $error("device drove SDA during write cycle");
    AST_DEV_STABLE: assert property (
        scl && $past(scl) |-> $stable(d_sda_oe))
        else $error("device changed SDA while SCL high");
    AST_START_FREE: assert property (
        $fell(sda) && scl && $past(scl) |-> !d_sda_oe)
        else $error("device held SDA at a START");
    AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
        else $error("SCL high phase too short");
    AST_BUSY_AT_STOP: assert property (
        $rose(write_busy) |-> scl && sda)
        else $error("write cycle began outside a STOP");
    AST_WP_BLOCK: assert property (
        $rose(write_busy) |-> !$past(write_protect_input, 8))
        else $error("write cycle began while protected");
    AST_BUSY_MAX: assert property (
        write_busy |-> busy_cnt_reg < WRITE_CYCLES + 2)
        else $error("write cycle too long");
    AST_BUSY_MIN: assert property (
        $fell(write_busy) |-> busy_cnt_reg > WRITE_CYCLES - 3)
        else $error("write cycle too short");
endmodule

`default_nettype wire

//--- dv/serial_eeprom_slave_protocol_tb.sv
/* Self-checking bench: master end and EEPROM end across the bus.
   Assumes sesp_consts.svh is on the include path. */
`include "sesp_consts.svh"
`default_nettype none

module serial_eeprom_slave_protocol_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WC = 600;
    localparam logic [2:0] CS = 3'h5;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_valid = 1'b0, cmd_start = 1'b0, cmd_stop = 1'b0;
    logic cmd_read = 1'b0, cmd_ack = 1'b0, rsp_ready = 1'b0;
    logic [7:0] cmd_data = 8'h00, rsp_data, lf = 8'h4C, rd = 8'h4C;
    logic cmd_ready, rsp_valid, rsp_ack, write_busy;
    logic write_protect_input = 1'b0, stall = 1'b0;
    logic [2:0] chip_select_pins = CS;
    logic [7:0] d [4];
    logic [8:0] expq [$];
    int bad_count = 0, comparisons = 0, cyc = 0;

    sesp_bus_if bus ();
    sesp_master i_sesp_master (.clk_sys, .arst_n, .bus, .cmd_valid,
        .cmd_ready, .cmd_start, .cmd_stop, .cmd_read, .cmd_ack, .cmd_data,
        .rsp_valid, .rsp_ready, .rsp_data, .rsp_ack);
    sesp_eeprom #(.WRITE_CYCLES(WC)) i_sesp_eeprom (.clk_sys, .arst_n,
        .bus, .chip_select_pins, .write_protect_input, .write_busy);
    sesp_monitor #(.WRITE_CYCLES(WC)) i_sesp_monitor (.clk_sys, .arst_n,
        .scl(bus.scl), .sda(bus.sda), .d_sda_oe(bus.d_sda_oe),
        .write_protect_input, .write_busy);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [7:0] cb(input logic [2:0] c, input logic r);
        return {`SESP_DEV_TYPE, c, r};
    endfunction

    task automatic results;
        $display("comparisons %0d bad %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // The expectation is queued before the command can possibly finish.
    task automatic cmd(input logic s, input logic p, input logic r,
        input logic a, input logic [7:0] dat, input logic [8:0] e);
        expq.push_back(e);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_start <= s;
        cmd_stop <= p;
        cmd_read <= r;
        cmd_ack <= a;
        cmd_data <= dat;
        @(posedge clk_sys);
        while (cmd_ready !== 1'b1)
            @(posedge clk_sys);
        cmd_valid <= 1'b0;
    endtask
    task automatic wb(input logic [7:0] v, input logic s, input logic p,
        input logic a);
        cmd(s, p, 1'b0, 1'b0, v, {v, a});
    endtask
    task automatic rb(input logic a, input logic p, input logic [7:0] e);
        cmd(1'b0, p, 1'b1, a, 8'h00, {e, a});
    endtask
    // The ignored top address bit is set on purpose.
    task automatic seta(input logic [14:0] ad);
        wb(cb(CS, 1'b0), 1'b1, 1'b0, 1'b1);
        wb({1'b1, ad[14:8]}, 1'b0, 1'b0, 1'b1);
        wb(ad[7:0], 1'b0, 1'b0, 1'b1);
    endtask
    task automatic drain;
        while (expq.size() != 0 || write_busy !== 1'b0)
            @(posedge clk_sys);
    endtask

    task automatic chk(input logic [8:0] got);
        logic [8:0] e;
        e = expq.pop_front();
        comparisons++;
        if (got !== e)
        begin
            bad_count++;
            $display("Error rsp expected %h seen %h", e, got);
        end
    endtask

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
            chk({rsp_data, rsp_ack});
        rsp_ready <= !stall && rd[0];
        rd = nxt(rd);
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            results();
        end
    end

    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            lf = nxt(lf);
            d[i] = lf;
        end
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        seta(15'h123E);
        for (int i = 0; i < 4; i++)
            wb(d[i], 1'b0, i == 3, 1'b1);
        wb(cb(CS, 1'b0), 1'b1, 1'b1, 1'b0);
        drain();
        $display("test 1 end");
        seta(15'h123E);
        wb(cb(CS, 1'b1), 1'b1, 1'b0, 1'b1);
        rb(1'b1, 1'b0, d[0]);
        rb(1'b0, 1'b1, d[1]);
        seta(15'h1200);
        wb(cb(CS, 1'b1), 1'b1, 1'b0, 1'b1);
        rb(1'b0, 1'b1, d[2]);
        wb(cb(CS, 1'b1), 1'b1, 1'b0, 1'b1);
        rb(1'b0, 1'b1, d[3]);
        drain();
        $display("test 2 end");
        write_protect_input <= 1'b1;
        seta(15'h1200);
        wb(~d[2], 1'b0, 1'b1, 1'b1);
        wb(cb(CS, 1'b0), 1'b1, 1'b1, 1'b1);
        drain();
        write_protect_input <= 1'b0;
        wb(cb(CS, 1'b1), 1'b1, 1'b0, 1'b1);
        rb(1'b0, 1'b1, d[3]);
        seta(15'h1200);
        wb(cb(CS, 1'b1), 1'b1, 1'b0, 1'b1);
        rb(1'b0, 1'b1, d[2]);
        drain();
        $display("test 3 end");
        stall <= 1'b1;
        fork
            begin
                repeat (3000) @(posedge clk_sys);
                stall <= 1'b0;
            end
        join_none
        wb({~`SESP_DEV_TYPE, CS, 1'b0}, 1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 8; i++)
            wb(cb(i[2:0], 1'b0), 1'b1, 1'b1, i == CS);
        drain();
        $display("test 4 end");
        results();
    end
endmodule

`default_nettype wire
